// file: rtl/alu_exec_pkg.sv
// constants, opcode patterns and carrier types for the four-instruction executor
// assumes a 16-bit instruction word and an 8-bit data path
package alu_exec_pkg;
  localparam logic [7:0] OPC_ADDC_HI   = 8'h20;  // 0010 00da
  localparam logic [7:0] OPC_ANDR_HI   = 8'h14;  // 0001 01da
  localparam logic [7:0] OPC_ANDI_HI   = 8'h0b;  // 0000 1011
  localparam logic [7:0] OPC_BRC_HI    = 8'he2;  // 1110 0010
  localparam logic [7:0] OPC_MASK6     = 8'hfc;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam int         D_BIT         = 9;
  localparam int         A_BIT         = 8;
  localparam logic [1:0] PH_DECODE     = 2'h0;
  localparam logic [1:0] PH_LAST       = 2'h3;
  localparam logic [20:0] PC_STEP      = 21'h000002;

  typedef enum logic [1:0] {
    ADDR_ACCESS  = 2'b00,
    ADDR_BANKED  = 2'b01,
    ADDR_INDEXED = 2'b10
  } addr_mode_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic nib_carry;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic       we;
    addr_mode_t mode;
    logic [7:0] addr;
    logic [7:0] data;
  } file_wr_t;
endpackage

// file: rtl/alu_exec.sv
// executor for add-with-carry, two ANDs and branch-on-carry
// assumes the fetch unit holds instr steady during a cycle and that the
// bank logic resolves file_rd_data combinationally from the file address
`timescale 1ns/1ps
`default_nettype none
module alu_exec
  import alu_exec_pkg::*;
#(
  parameter int PC_W = 21
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  input  wire logic [15:0]              instr,
  input  wire logic                     instr_valid,
  input  wire logic                     ext_set_en,
  input  wire logic [3:0]               bank_select_reg,
  input  wire logic [7:0]               file_rd_data,
  output var  logic [7:0]               file_rd_addr,
  output var  alu_exec_pkg::addr_mode_t file_rd_mode,
  output var  alu_exec_pkg::file_wr_t   file_wr,
  output var  logic [7:0]               wreg,
  output var  alu_exec_pkg::flags_t     status,
  output var  logic [PC_W-1:0]          pc,
  output var  logic [1:0]               phase,
  output var  logic                     instr_done,
  output var  logic                     branch_flush
);
  import alu_exec_pkg::*;

  // elaboration check: the branch target needs nine to 21 pc bits
  if (PC_W < 9 || PC_W > 21) begin : g_pc_w_check
    $error("PC_W out of range");
  end

  // elaboration check: operand fields sit in the opcode byte
  if (D_BIT < A_BIT || D_BIT > 15 || A_BIT < 8) begin : g_field_check
    $error("operand field positions out of range");
  end

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01
  } state_t;

  // reset release through two flops
  logic rst_s1_q;
  logic rst_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // logic operations move only negative and zero
  function automatic flags_t nz_only(flags_t old, logic [7:0] r);
    flags_t f;
    f      = old;
    f.neg  = r[7];
    f.zero = (r == 8'h00);
    return f;
  endfunction

  // operand addressing of a file-register instruction
  function automatic addr_mode_t mode_of(logic a, logic ext, logic [7:0] f);
    addr_mode_t m;
    if (a) m = ADDR_BANKED;
    else if (ext && f <= INDEXED_LIMIT) m = ADDR_INDEXED;
    else m = ADDR_ACCESS;
    return m;
  endfunction

  // opcode byte against a pattern under a mask
  function automatic logic op_match(logic [7:0] hi, logic [7:0] pat,
                                    logic [7:0] mask);
    return (hi & mask) == pat;
  endfunction

  wire logic [7:0] hi_op   = instr[15:8];
  wire logic       is_addc = op_match(hi_op, OPC_ADDC_HI, OPC_MASK6);
  wire logic       is_andr = op_match(hi_op, OPC_ANDR_HI, OPC_MASK6);
  wire logic       is_andi = op_match(hi_op, OPC_ANDI_HI, 8'hff);
  wire logic       is_brc  = op_match(hi_op, OPC_BRC_HI, 8'hff);
  wire logic       d_bit   = instr[D_BIT];
  wire logic       a_bit   = instr[A_BIT];
  wire logic [7:0] f_addr  = instr[7:0];
  wire logic [7:0] k_lit   = instr[7:0];
  wire logic [7:0] br_off  = instr[7:0];

  wire addr_mode_t mode_w = mode_of(a_bit, ext_set_en, f_addr);

  wire logic [8:0] sum9 = {1'b0, wreg} + {1'b0, file_rd_data}
                          + {8'h00, status.carry};
  wire logic [4:0] sum5 = {1'b0, wreg[3:0]} + {1'b0, file_rd_data[3:0]}
                          + {4'h0, status.carry};
  wire logic ovf_w = (wreg[7] == file_rd_data[7]) && (sum9[7] != wreg[7]);
  wire flags_t add_flags = '{neg: sum9[7], ovf: ovf_w,
                             zero: (sum9[7:0] == 8'h00),
                             nib_carry: sum5[4], carry: sum9[8]};

  wire logic [7:0] and_f = wreg & file_rd_data;
  wire logic [7:0] and_k = wreg & k_lit;

  // signed doubled offset on advanced pc
  wire logic [PC_W-1:0] off_ext = PC_W'({{(PC_W-8){br_off[7]}}, br_off});
  wire logic [PC_W-1:0] pc_next = pc + PC_W'(PC_STEP);
  wire logic [PC_W-1:0] pc_tgt  = pc_next + (off_ext << 1);

  state_t          state_q;
  logic [1:0]      phase_q;
  wire logic       last_ph  = phase_q == PH_LAST;
  wire logic       first_ph = phase_q == PH_DECODE;
  // the cycle after a taken branch executes nothing
  wire logic       in_flush = state_q == ST_FLUSH;
  wire logic       exec_go  = clk_en && last_ph && !in_flush
                              && instr_valid;
  wire logic       take_br  = is_brc && status.carry;

  wire logic       file_op   = is_addc || is_andr;
  wire logic [7:0] alu_res   = is_addc ? sum9[7:0]
                                       : (is_andr ? and_f : and_k);
  wire logic       to_file   = file_op && d_bit;
  wire logic       to_acc    = (file_op && !d_bit) || is_andi;
  wire logic       flag_upd  = file_op || is_andi;
  // logic ops move only N and Z
  // register and uses the file operand
  wire flags_t     flags_new = is_addc ? add_flags
                                       : nz_only(status, alu_res);

  // next values of the architectural state
  wire logic [PC_W-1:0] pc_d      = take_br ? pc_tgt : pc_next;
  wire logic [7:0]      wreg_d    = to_acc ? alu_res : wreg;
  wire flags_t          status_d  = flag_upd ? flags_new : status;
  wire file_wr_t        file_wr_d = '{we: to_file, mode: mode_w,
                                      addr: f_addr, data: alu_res};

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) phase_q <= PH_DECODE;
    else if (clk_en) phase_q <= phase_q + 2'h1;
  end
  assign phase = phase_q;

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) state_q <= ST_EXEC;
    else if (clk_en && last_ph) begin
      unique case (state_q)
        ST_EXEC:  state_q <= (instr_valid && take_br) ? ST_FLUSH : ST_EXEC;
        ST_FLUSH: state_q <= ST_EXEC;
        default:  state_q <= ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      file_rd_addr <= 8'h00;
      file_rd_mode <= ADDR_ACCESS;
    end else if (clk_en && first_ph) begin
      file_rd_addr <= f_addr;
      file_rd_mode <= mode_w;
    end
  end

  // state updates once per instruction cycle
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      wreg         <= 8'h00;
      status       <= '0;
      file_wr      <= '0;
      pc           <= '0;
      instr_done   <= 1'b0;
      branch_flush <= 1'b0;
    end else if (clk_en) begin
      file_wr.we   <= 1'b0;
      instr_done   <= 1'b0;
      branch_flush <= 1'b0;
      if (exec_go) begin
        instr_done   <= 1'b1;
        pc           <= pc_d;
        branch_flush <= take_br;
        file_wr      <= file_wr_d;
        wreg         <= wreg_d;
        status       <= status_d;
      end
    end
  end

  // the bank number is applied outside, steered by file_rd_mode
  wire logic unused_bank = ^bank_select_reg;
endmodule
`default_nettype wire

// file: sim/alu_exec_sva.sv
// assertions on the executor ports
// assumes clk_en is held high by the surroundings
`timescale 1ns/1ps
`default_nettype none
module alu_exec_sva
  import alu_exec_pkg::*;
#(parameter int PC_W = 21) (
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic [15:0]            instr,
  input wire logic [7:0]             file_rd_data,
  input wire alu_exec_pkg::file_wr_t file_wr,
  input wire logic [7:0]             wreg,
  input wire alu_exec_pkg::flags_t   status,
  input wire logic [PC_W-1:0]        pc,
  input wire logic [1:0]             phase,
  input wire logic                   instr_done,
  input wire logic                   branch_flush
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ph_step_a: assert property (
    phase != 2'h0 |=> phase == $past(phase) + 2'h1) else $error("phase");
  done_ph_a: assert property (
    instr_done |-> phase == PH_DECODE) else $error("done phase");
  wr_pulse_a: assert property (
    file_wr.we |=> !file_wr.we) else $error("write held");
  and_file_a: assert property (
    instr_done && $past(instr[15:9]) == 7'h0b |-> file_wr.we && wreg ==
    $past(wreg) && file_wr.data == ($past(wreg) & $past(file_rd_data)))
    else $error("file and");
  and_imm_a: assert property (
    instr_done && $past(instr[15:8]) == OPC_ANDI_HI |->
    wreg == ($past(wreg) & $past(instr[7:0])) && status.zero == (wreg == 8'h00)
    && status.carry == $past(status.carry)) else $error("and");
  add_acc_a: assert property (
    instr_done && $past(instr[15:9]) == 7'h10 |-> {status.carry, wreg} ==
    $past(wreg) + $past(file_rd_data) + $past(status.carry)) else $error("sum");
  add_file_a: assert property (
    instr_done && $past(instr[15:9]) == 7'h11 |-> file_wr.we && wreg ==
    $past(wreg) && file_wr.data == 8'($past(wreg) + $past(file_rd_data)
    + $past(status.carry))) else $error("file sum");
  br_dest_a: assert property (
    branch_flush |-> pc == PC_W'($past(pc) + 2 + {{(PC_W-9){$past(instr[7])}},
    $past(instr[7:0]), 1'b0})) else $error("target");
  br_idle_a: assert property (
    branch_flush |=> !instr_done [*7]) else $error("flush");
endmodule
bind alu_exec alu_exec_sva #(.PC_W(PC_W)) i_sva (.mclk(mclk),
  .reset_n(reset_n), .instr(instr), .file_rd_data(file_rd_data),
  .file_wr(file_wr), .wreg(wreg), .status(status), .pc(pc), .phase(phase),
  .instr_done(instr_done), .branch_flush(branch_flush));
`default_nettype wire

// file: sim/tb_top.sv
// table-driven bench for the executor, then a mid-run reset
// assumes the checker is bound in; the operand is driven directly
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_errors++; $display("Error %0t: %h vs %h", $time, a, b); end end
module tb_top;
  import alu_exec_pkg::*;
  typedef struct packed {logic [15:0] op; logic [7:0] fd, w, st;
    logic [3:0] md, wf; logic [7:0] pc;} row_t;
  logic        mclk = 1'b0, reset_n = 1'b0, instr_done, branch_flush;
  logic        instr_valid = 1'b0, clk_en = 1'b1, prev_flush = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0]  file_rd_data = 8'h00, wreg, file_rd_addr;
  logic [1:0]  phase;
  logic [20:0] pc;
  file_wr_t    file_wr;
  flags_t      status;
  addr_mode_t  file_rd_mode;
  int          n_errors = 0, samples_checked = 0;
  // op, operand, wreg, flags, mode, write and flush, pc
  row_t        rows [13] = '{
    56'h205f4d4d002002, 56'h2060ff4c030004, 56'h0ba30000070006,
    56'h21020203001008, 56'h2080fcff10000a, 56'h1580808010100c,
    56'h228080800d020e, 56'h16400f800d2210, 56'he2fe00800d010e,
    56'h0b0000800d000e, 56'h0b0000000d0010, 56'h20800001000012,
    56'he2050001000014};
  alu_exec i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .instr(instr), .instr_valid(instr_valid), .ext_set_en(1'b1),
    .bank_select_reg(4'h3), .file_rd_data(file_rd_data),
    .file_rd_addr(file_rd_addr),
    .file_rd_mode(file_rd_mode), .file_wr(file_wr), .wreg(wreg),
    .status(status), .pc(pc), .phase(phase), .instr_done(instr_done),
    .branch_flush(branch_flush));
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one instruction cycle: wait for decode, drive, check after execution
  task automatic do_row(input row_t r);
    for (int k = 0; k < 8 && phase !== 2'h0; k++) tick(1);
    `CHK(phase, 2'h0)
    if (phase !== 2'h0) wrap_up();
    instr = r.op;
    instr_valid = 1'b1;
    file_rd_data = r.fd;
    tick(4);
    `CHK(wreg, r.w)
    `CHK(status, r.st[4:0])
    `CHK(file_wr.we, r.wf[1])
    `CHK(branch_flush, r.wf[0])
    `CHK(pc[7:0], r.pc)
    `CHK(instr_done, !prev_flush)
    `CHK(file_rd_addr, r.op[7:0])
    if (r.op[15:14] == 2'b00 && r.op[11:8] != 4'hb)
      `CHK(file_rd_mode, r.md[1:0])
    if (r.wf[1]) begin
      `CHK(file_wr.addr, r.op[7:0])
      `CHK(file_wr.mode, r.md[1:0])
    end
    prev_flush = r.wf[0];
  endtask
  initial forever #25 mclk = ~mclk;
  initial begin
    tick(2);
    reset_n = 1'b1;
    tick(2);
    `CHK(phase, 2'h0)
    `CHK(pc, 21'h000000)
    tick(2);
    foreach (rows[i]) do_row(rows[i]);
    // valid low: nothing executes
    instr_valid = 1'b0;
    instr = 16'h0b00;
    tick(4);
    `CHK(instr_done, 1'b0)
    `CHK(wreg, 8'h01)
    `CHK(pc[7:0], 8'h14)
    // enable low: the phase counter holds
    clk_en = 1'b0;
    tick(4);
    `CHK(phase, 2'h0)
    clk_en = 1'b1;
    reset_n = 1'b0;
    prev_flush = 1'b0;
    #5;
    `CHK(pc, 21'h000000)
    `CHK(wreg, 8'h00)
    tick(1);
    reset_n = 1'b1;
    tick(4);
    do_row(rows[0]);
    wrap_up();
  end
endmodule
`default_nettype wire
